// >>> lcp_regs.svh
// Constants for the link control protocol entity
`ifndef LCP_REGS_SVH
`define LCP_REGS_SVH
`define LCP_CLK_HZ 100000000
`define LCP_TIMER_MS 1000
`define LCP_TIMER_CYCLES ((`LCP_CLK_HZ / 1000) * `LCP_TIMER_MS)
`define LCP_FUNC_W 7
`define LCP_ADDR_W 16
`define LCP_FUNC_MAX 7'h07
`define LCP_MSG_LC 2'h1
`define LCP_MSG_ACK 2'h2
`define LCP_FIFO_DEPTH 4
`endif

// >>> lcp_pkg.sv
// Types for the link control protocol entity
package lcp_pkg;
	typedef enum logic [1:0]
	{
		LCP_OUT_OF_SERVICE = 2'h0,
		LCP_IN_SERVICE = 2'h1,
		LCP_AWAIT_ACK = 2'h3
	} lcp_state_e;
endpackage

// >>> lcp_ack_timer.sv
// Acknowledgement wait timer with one-cycle expiry pulse
`timescale 1ns/1ps
`include "lcp_regs.svh"
module lcp_ack_timer #(
	parameter int unsigned CYCLES = `LCP_TIMER_CYCLES
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Control
	input wire logic start,
	input wire logic stop,
	// Status
	output logic running,
	output logic expired
);
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic run_r;
	logic run_nxt;
	logic exp_r;
	logic exp_nxt;

	if (CYCLES < 2)
	begin : g_cycles_check
		$error("Timer count too small");
	end

	always_comb
	begin
		cnt_nxt = cnt_r;
		run_nxt = run_r;
		exp_nxt = 1'b0;
		if (start)
		begin
			cnt_nxt = 32'(CYCLES - 1);
			run_nxt = 1'b1;
		end
		else if (stop)
			run_nxt = 1'b0;
		else if (run_r)
		begin
			if (cnt_r == 32'h0)
			begin
				run_nxt = 1'b0;
				exp_nxt = 1'b1;
			end
			else
				cnt_nxt = cnt_r - 32'h1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_r <= 32'h0;
			run_r <= 1'b0;
			exp_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			run_r <= run_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign running = run_r;
	assign expired = exp_r;
endmodule

// >>> lcp_entity.sv
// Link control protocol entity: message checks, state machine, request store
// What this block does
// R1: Bad, unknown or foreign link address: error indication, message dropped.
// R2: Unknown message type: error indication, message dropped.
// R3: Repeated mandatory element: error indication, message dropped.
// R4: Missing mandatory element: error indication, message dropped.
// R5: Unknown elements removed, processing continues, error indication also sent.
// R6: Bad length or undefined content in mandatory element: error, drop.
// R7: Acknowledgement timer lasts one second within ten percent.
// R8: Timer starts on every sent link control message, stops on matching acknowledgement.
// R9: Function request while awaiting acknowledgement is stored unless the store is full, state unchanged.
// R10: Received link control message in service or awaiting: acknowledge and forward to management; dropped without either if a message is sent that cycle.
// R11: Unexpected acknowledgement in service, or expiry, is ignored without state change.
// R12: Out of service, message or request gives error indication, no change.
// R13: In service, request sends message, starts timer, enters awaiting state.
// R14: First expiry resends and restarts; second reports error, back in service.
// R15: Stop traffic stops timer, goes out of service; start enters service.
// R16: Acknowledgement while awaiting stops timer, returns, then sends oldest stored request.
`timescale 1ns/1ps
`include "lcp_regs.svh"
module lcp_entity #(
	parameter int unsigned TIMER_CYCLES = `LCP_TIMER_CYCLES, //R7
	parameter int unsigned DEPTH = `LCP_FIFO_DEPTH,
	parameter logic [`LCP_ADDR_W-1:0] LINK_ADDR = 16'h0001
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Management commands
	input wire logic mgmt_start_traffic_cmd,
	input wire logic mgmt_stop_traffic_cmd,
	// Function request from management
	input wire logic function_request_primitive,
	input wire logic [`LCP_FUNC_W-1:0] req_func,
	// Parsed received message from data link
	input wire logic rx_valid,
	input wire logic [1:0] rx_type,
	input wire logic rx_type_known,
	input wire logic rx_addr_coding_ok,
	input wire logic [`LCP_ADDR_W-1:0] rx_addr,
	input wire logic rx_ie_repeated,
	input wire logic rx_ie_missing,
	input wire logic rx_ie_unknown,
	input wire logic rx_ie_len_ok,
	input wire logic [`LCP_FUNC_W-1:0] rx_func,
	// Transmit to data link
	output logic tx_valid,
	output logic [1:0] tx_type,
	output logic [`LCP_ADDR_W-1:0] tx_addr,
	output logic [`LCP_FUNC_W-1:0] tx_func,
	// Indications to management
	output logic mgmt_error_indication,
	output logic fwd_valid,
	output logic [`LCP_FUNC_W-1:0] fwd_func,
	output logic [`LCP_ADDR_W-1:0] fwd_addr,
	output logic [1:0] state,
	output logic store_full
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 1 || DEPTH > 256)
	begin : g_depth_check
		$error("Store depth out of range");
	end

	// Reset release
	logic rs1_r;
	logic rs2_r;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rs1_r <= 1'b0;
			rs2_r <= 1'b0;
		end
		else
		begin
			rs1_r <= 1'b1;
			rs2_r <= rs1_r;
		end
	end
	wire logic srst_n = rs2_r;

	// Timer
	logic tmr_start;
	logic tmr_stop;
	logic tmr_run;
	logic tmr_exp;
	lcp_ack_timer #(.CYCLES(TIMER_CYCLES)) u_timer
	(
		.sys_clk(sys_clk),
		.rst_n(srst_n),
		.start(tmr_start),
		.stop(tmr_stop),
		.running(tmr_run),
		.expired(tmr_exp)
	);

	// Received message checks
	logic rx_drop;
	logic rx_soft_err;
	logic rx_ok;
	always_comb
	begin
		rx_drop = 1'b0;
		if (!rx_addr_coding_ok || rx_addr != LINK_ADDR) //R1
			rx_drop = 1'b1;
		else if (!rx_type_known) //R2
			rx_drop = 1'b1;
		else if (rx_ie_repeated) //R3
			rx_drop = 1'b1;
		else if (rx_ie_missing) //R4
			rx_drop = 1'b1;
		else if (rx_type == `LCP_MSG_LC && (!rx_ie_len_ok || rx_func > `LCP_FUNC_MAX)) //R6
			rx_drop = 1'b1;
		rx_soft_err = !rx_drop && rx_ie_unknown; //R5
		rx_ok = rx_valid && !rx_drop;
	end

	// Stored requests
	logic [`LCP_FUNC_W-1:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] wp_nxt;
	logic [PW-1:0] rp_r;
	logic [PW-1:0] rp_nxt;
	logic [PW:0] cnt_r;
	logic [PW:0] cnt_nxt;
	logic push;
	logic pop;

	// Protocol state
	lcp_pkg::lcp_state_e st_r;
	lcp_pkg::lcp_state_e st_nxt;
	logic retry_r;
	logic retry_nxt;
	logic [`LCP_FUNC_W-1:0] cur_r;
	logic [`LCP_FUNC_W-1:0] cur_nxt;
	logic txv_nxt;
	logic [1:0] txt_nxt;
	logic [`LCP_FUNC_W-1:0] txf_nxt;
	logic err_nxt;
	logic fwdv_nxt;
	logic [`LCP_FUNC_W-1:0] fwdf_nxt;
	logic [`LCP_ADDR_W-1:0] fwda_nxt;
	logic [`LCP_ADDR_W-1:0] fwda_r;
	logic [`LCP_FUNC_W-1:0] fwdf_r;
	logic fwdv_r;
	logic err_r;
	logic txv_r;
	logic [1:0] txt_r;
	logic [`LCP_FUNC_W-1:0] txf_r;

	always_comb
	begin
		st_nxt = st_r; //R11
		retry_nxt = retry_r;
		cur_nxt = cur_r;
		txv_nxt = 1'b0;
		txt_nxt = txt_r;
		txf_nxt = txf_r;
		err_nxt = 1'b0;
		fwdv_nxt = 1'b0;
		fwdf_nxt = fwdf_r;
		fwda_nxt = fwda_r;
		tmr_start = 1'b0;
		tmr_stop = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		if (rx_valid && (rx_drop || rx_soft_err)) //R1 R2 R3 R4 R5 R6
			err_nxt = 1'b1;
		if (mgmt_stop_traffic_cmd && st_r != lcp_pkg::LCP_OUT_OF_SERVICE)
		begin
			tmr_stop = 1'b1; //R15
			st_nxt = lcp_pkg::LCP_OUT_OF_SERVICE;
		end
		else
		begin
			unique case (st_r)
				lcp_pkg::LCP_OUT_OF_SERVICE:
				begin
					if (mgmt_start_traffic_cmd)
						st_nxt = lcp_pkg::LCP_IN_SERVICE; //R15
					if (function_request_primitive || rx_ok) //R12
						err_nxt = 1'b1;
				end
				lcp_pkg::LCP_IN_SERVICE:
				begin
					if (function_request_primitive || cnt_r != '0)
					begin
						cur_nxt = (cnt_r != '0) ? mem_r[rp_r] : req_func; //R16
						pop = (cnt_r != '0);
						push = (cnt_r != '0) && function_request_primitive;
						txv_nxt = 1'b1; //R13
						txt_nxt = `LCP_MSG_LC;
						txf_nxt = cur_nxt;
						tmr_start = 1'b1; //R8
						retry_nxt = 1'b0;
						st_nxt = lcp_pkg::LCP_AWAIT_ACK;
					end
				end
				lcp_pkg::LCP_AWAIT_ACK:
				begin
					if (function_request_primitive)
						push = 1'b1; //R9
					if (rx_ok && rx_type == `LCP_MSG_ACK)
					begin
						tmr_stop = 1'b1; //R16
						st_nxt = lcp_pkg::LCP_IN_SERVICE;
					end
					else if (tmr_exp && !retry_r)
					begin
						txv_nxt = 1'b1; //R14
						txt_nxt = `LCP_MSG_LC;
						txf_nxt = cur_r;
						tmr_start = 1'b1;
						retry_nxt = 1'b1;
					end
					else if (tmr_exp)
					begin
						err_nxt = 1'b1; //R14
						st_nxt = lcp_pkg::LCP_IN_SERVICE;
					end
				end
				default:
					st_nxt = lcp_pkg::LCP_OUT_OF_SERVICE;
			endcase
		end
		if (rx_ok && rx_type == `LCP_MSG_LC && st_r != lcp_pkg::LCP_OUT_OF_SERVICE
			&& !txv_nxt)
		begin
			txv_nxt = 1'b1; //R10
			txt_nxt = `LCP_MSG_ACK;
			txf_nxt = rx_func;
			fwdv_nxt = 1'b1;
			fwdf_nxt = rx_func;
			fwda_nxt = rx_addr;
		end
		// Acknowledgements in service and stray expiries fall through //R11
	end

	always_comb
	begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push && (cnt_r < (PW+1)'(DEPTH) || pop))
		begin
			wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
			cnt_nxt = cnt_nxt + (PW+1)'(1);
		end
		if (pop)
		begin
			rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
			cnt_nxt = cnt_nxt - (PW+1)'(1);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (push && (cnt_r < (PW+1)'(DEPTH) || pop))
			mem_r[wp_r] <= req_func;
	end

	always_ff @(posedge sys_clk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			st_r <= lcp_pkg::LCP_OUT_OF_SERVICE;
			retry_r <= 1'b0;
			cur_r <= '0;
			txv_r <= 1'b0;
			txt_r <= 2'h0;
			txf_r <= '0;
			err_r <= 1'b0;
			fwdv_r <= 1'b0;
			fwdf_r <= '0;
			fwda_r <= '0;
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			retry_r <= retry_nxt;
			cur_r <= cur_nxt;
			txv_r <= txv_nxt;
			txt_r <= txt_nxt;
			txf_r <= txf_nxt;
			err_r <= err_nxt;
			fwdv_r <= fwdv_nxt;
			fwdf_r <= fwdf_nxt;
			fwda_r <= fwda_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign tx_valid = txv_r;
	assign tx_type = txt_r;
	assign tx_addr = LINK_ADDR;
	assign tx_func = txf_r;
	assign mgmt_error_indication = err_r;
	assign fwd_valid = fwdv_r;
	assign fwd_func = fwdf_r;
	assign fwd_addr = fwda_r;
	assign state = st_r;
	assign store_full = (cnt_r == (PW+1)'(DEPTH));
endmodule

// >>> lcp_entity_checker.sv
// Port assertions for the link control entity
`timescale 1ns/1ps
module lcp_entity_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Inputs
	input wire logic mgmt_start_traffic_cmd,
	input wire logic mgmt_stop_traffic_cmd,
	input wire logic function_request_primitive,
	input wire logic rx_valid,
	input wire logic rx_type_known,
	// Outputs
	input wire logic tx_valid,
	input wire logic [1:0] tx_type,
	input wire logic mgmt_error_indication,
	input wire logic fwd_valid,
	input wire logic [1:0] state
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	bad_type_a: assert property (rx_valid && !rx_type_known |=> mgmt_error_indication)
		else $error("no error on bad type");
	type_drop_a: assert property (rx_valid && !rx_type_known |=> !fwd_valid)
		else $error("bad type forwarded");
	fwd_cause_a: assert property (fwd_valid |-> $past(rx_valid) && $past(rx_type_known))
		else $error("forward without message");
	ack_cause_a: assert property (tx_valid && tx_type == 2'h2 |-> $past(rx_valid))
		else $error("ack without message");
	stop_oos_a: assert property (mgmt_stop_traffic_cmd |=> state == 2'h0)
		else $error("stop missed");
	start_in_a: assert property (state == 2'h0 && mgmt_start_traffic_cmd
		&& !mgmt_stop_traffic_cmd |=> state == 2'h1)
		else $error("start missed");
	oos_req_a: assert property (state == 2'h0 && function_request_primitive
		&& !mgmt_start_traffic_cmd |=> mgmt_error_indication && !tx_valid)
		else $error("request out of service");
	req_send_a: assert property (state == 2'h1 && function_request_primitive
		&& !mgmt_stop_traffic_cmd |=> tx_valid && tx_type == 2'h1 && state == 2'h3)
		else $error("request not sent");
	oos_stay_a: assert property (state == 2'h0 && !mgmt_start_traffic_cmd |=> state == 2'h0)
		else $error("left out of service");
	c_send: cover property (state == 2'h1 ##1 state == 2'h3);
	c_ack: cover property (state == 2'h3 ##1 state == 2'h1);
	c_fwd: cover property (fwd_valid);
endmodule
bind lcp_entity lcp_entity_checker i_lcp_entity_checker (.sys_clk(sys_clk), .rst_n(rst_n),
	.mgmt_start_traffic_cmd(mgmt_start_traffic_cmd), .rx_valid(rx_valid),
	.mgmt_stop_traffic_cmd(mgmt_stop_traffic_cmd), .rx_type_known(rx_type_known),
	.function_request_primitive(function_request_primitive), .tx_valid(tx_valid),
	.tx_type(tx_type), .mgmt_error_indication(mgmt_error_indication),
	.fwd_valid(fwd_valid), .state(state));

// >>> lcp_peer.sv
// Peer entity model acknowledging link control messages
`timescale 1ns/1ps
module lcp_peer (
	// Clock
	input wire logic sys_clk,
	// From entity
	input wire logic tx_valid,
	input wire logic [1:0] tx_type,
	// Control
	input wire logic ack_en,
	input wire logic [3:0] dly,
	// To entity
	output logic p_valid,
	output logic [1:0] p_type
);
	int cnt = -1;
	initial
	begin
		p_valid = 1'b0;
		p_type = 2'h1;
		forever
		begin
			@(negedge sys_clk);
			p_valid <= 1'b0;
			p_type <= ~p_type;
			if (cnt == 0)
			begin
				p_valid <= 1'b1;
				p_type <= 2'h2;
			end
			if (cnt >= 0) cnt <= cnt - 1;
			if (tx_valid && tx_type == 2'h1 && ack_en) cnt <= dly;
		end
	end
endmodule

// >>> test_link_ctrl_protocol_fsm.sv
// Bench for the link control entity
`timescale 1ns/1ps
module test_link_ctrl_protocol_fsm;
	localparam int T = 20;
	logic sys_clk = 0, rst_n = 0, st = 0, sp = 0, fr = 0, tv = 0, ae = 1;
	logic kn = 1, co = 1, rp = 0, ms = 0, un = 0, ln = 1, pv, txv, mei, fv, sf;
	logic [1:0] tt = 2'h1, pt, ty, state;
	logic [3:0] dly = 4'h3;
	logic [6:0] rf = 7'h00, rfn = 7'h04, tf, ff;
	logic [15:0] ra = 16'h0001, ta, fa;
	int err_total = 0, cmp_count = 0, ne = 0, nl = 0, na = 0, nf = 0, be, bl, ba, bf;
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		ne <= ne + (mei === 1'b1);
		nl <= nl + (txv === 1'b1 && ty === 2'h1);
		na <= na + (txv === 1'b1 && ty === 2'h2);
		nf <= nf + (fv === 1'b1);
	end
	lcp_entity #(.TIMER_CYCLES(T)) i_lcp_entity (.sys_clk(sys_clk), .rst_n(rst_n),
		.mgmt_start_traffic_cmd(st), .mgmt_stop_traffic_cmd(sp),
		.function_request_primitive(fr), .req_func(rf), .rx_valid(pv | tv),
		.rx_type(pv ? pt : tt), .rx_type_known(kn), .rx_addr_coding_ok(co), .rx_addr(ra),
		.rx_ie_repeated(rp), .rx_ie_missing(ms), .rx_ie_unknown(un), .rx_ie_len_ok(ln),
		.rx_func(rfn), .tx_valid(txv), .tx_type(ty), .tx_addr(ta), .tx_func(tf),
		.mgmt_error_indication(mei), .fwd_valid(fv), .fwd_func(ff), .fwd_addr(fa),
		.state(state), .store_full(sf));
	lcp_peer i_lcp_peer (.sys_clk(sys_clk), .tx_valid(txv), .tx_type(ty), .ack_en(ae),
		.dly(dly), .p_valid(pv), .p_type(pt));
	task chk(string n, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s exp %0h got %0h", n, e, g);
		end
	endtask
	task snap;
		be = ne;
		bl = nl;
		ba = na;
		bf = nf;
	endtask
	task rx(logic [1:0] t);
		@(negedge sys_clk);
		tv = 1;
		tt = t;
		@(negedge sys_clk);
		{tv, kn, co, ra, rp, ms, un, ln, rfn} = {3'h3, 16'h0001, 4'h1, 7'h04};
		repeat (2) @(negedge sys_clk);
	endtask
	task req(logic [6:0] f);
		@(negedge sys_clk);
		fr = 1;
		rf = f;
		@(negedge sys_clk);
		fr = 0;
		@(negedge sys_clk);
	endtask
	task t_oos;
		snap;
		req(7'h03);
		rx(2'h1);
		chk("oos err", 2, ne - be);
		chk("oos tx", 0, nl + na - bl - ba);
		@(negedge sys_clk);
		st = 1;
		@(negedge sys_clk);
		st = 0;
		chk("start", 1, state);
		$display("oos done");
	endtask
	task t_drop;
		for (int k = 0; k < 7; k++)
		begin
			snap;
			case (k)
				0: co = 0;
				1: ra = 16'h0002;
				2: kn = 0;
				3: rp = 1;
				4: ms = 1;
				5: ln = 0;
				default: rfn = 7'h08;
			endcase
			rx(2'h1);
			chk("drop err", 1, ne - be);
			chk("drop out", 0, nf + na - bf - ba);
		end
		$display("drop done");
	endtask
	task t_recv;
		snap;
		un = 1;
		rx(2'h1);
		chk("ie err", 1, ne - be);
		chk("fwd", 1, nf - bf);
		chk("ack", 1, na - ba);
		chk("fwd func", 4, ff);
		chk("fwd addr", 1, fa);
		chk("ack func", 4, tf);
		rx(2'h2);
		chk("ack ignored", 1, ne - be);
		chk("ack state", 1, state);
		chk("ack no tx", 1, na + nl - ba - bl);
		$display("recv done");
	endtask
	task t_req;
		snap;
		req(7'h05);
		chk("await", 3, state);
		chk("tx func", 5, tf);
		chk("tx addr", 1, ta);
		req(7'h06);
		chk("stored", 3, state);
		repeat (40) @(negedge sys_clk);
		chk("sent", 2, nl - bl);
		chk("back", 1, state + ne - be + sf);
		chk("stored func", 6, tf);
		$display("req done");
	endtask
	task t_exp;
		ae = 0;
		snap;
		req(7'h01);
		repeat (T - 3) @(negedge sys_clk);
		chk("early", 1, nl - bl);
		repeat (T + 8) @(negedge sys_clk);
		chk("resend", 2, nl - bl);
		chk("exp err", 1, ne - be);
		chk("exp state", 1, state);
		chk("resend func", 1, tf);
		req(7'h02);
		sp = 1;
		@(negedge sys_clk);
		sp = 0;
		repeat (T + 5) @(negedge sys_clk);
		chk("stop", 0, state + nl - bl - 3);
		$display("exp done");
	endtask
	task wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#100000;
		err_total++;
		wrap_up;
	end
	initial
	begin
		repeat (16) @(negedge sys_clk);
		rst_n = 1;
		repeat (4) @(negedge sys_clk);
		t_oos;
		t_drop;
		t_recv;
		t_req;
		t_exp;
		wrap_up;
	end
endmodule
